// ---- rtl/mem_type_pkg.sv ----
// constants and types for the page memory-type selection block
//
// How it works
// - eight-entry memory type table, reset loads a default type into every entry
// - small page: upper index bit comes from page entry bit seven
// - either paging extension forces small-page upper index bit to zero
// - large page: upper index bit from directory entry bit 12
// - basic paging, no extension: all eight entries reachable for small pages
// - reset table holds weak uncacheable at cache-disable 1, write-through 0
// - ranges off, caching on, default table: weak uncacheable as write back
// - cache off, range regs off, default table: flags uncacheable ordering hazard
package mem_type_pkg;
  localparam int          ENTRIES      = 8;
  localparam int          IDX_W        = 3;
  localparam int          TYPE_W       = 3;
  localparam int          SMALL_UP_BIT = 7;
  localparam int          LARGE_UP_BIT = 12;
  localparam int          ENTRY_W      = 32;
  // register byte addresses
  localparam logic [11:0] TABLE_LO_ADR = 12'h000;
  localparam logic [11:0] TABLE_HI_ADR = 12'h004;
  localparam logic [11:0] CTRL_ADR     = 12'h008;
  localparam logic [11:0] STATUS_ADR   = 12'h00C;
  // control bit positions
  localparam int          CTL_LPME     = 0;
  localparam int          CTL_EAME     = 1;
  localparam int          CTL_GCD      = 2;
  localparam int          CTL_RANGE_EN = 3;
  // memory type encodings
  localparam logic [2:0]  UNCACHEABLE_TYPE      = 3'h0;
  localparam logic [2:0]  WRITE_COMBINE_TYPE    = 3'h1;
  localparam logic [2:0]  WRITE_THROUGH_TYPE    = 3'h4;
  localparam logic [2:0]  WRITE_PROTECT_TYPE    = 3'h5;
  localparam logic [2:0]  WRITE_BACK_TYPE       = 3'h6;
  localparam logic [2:0]  WEAK_UNCACHEABLE_TYPE = 3'h7;
  // default table: entry i is 8 bits, type in low 3 bits
  localparam logic [63:0] TABLE_RESET = 64'h0007040600070406;
  localparam logic [3:0]  CTRL_RESET  = 4'h8;
endpackage

// ---- rtl/mem_type_index.sv ----
// three-bit table index former for one translation
`timescale 1ns/100ps
module mem_type_index
  import mem_type_pkg::*;
(
  input  wire logic               large_page_i,         // large page
  input  wire logic [ENTRY_W-1:0] entry_i,              // page or dir entry
  input  wire logic               page_cache_disable_i, // entry cache bit
  input  wire logic               page_write_through_i, // entry wt bit
  input  wire logic               lpme_i,               // large page mode
  input  wire logic               eame_i,               // extended addr mode
  output logic      [IDX_W-1:0]   index_o               // table index
);
  wire small_up = entry_i[SMALL_UP_BIT];
  wire forced   = lpme_i | eame_i;
  wire up_bit   = large_page_i ? entry_i[LARGE_UP_BIT]
                : (forced ? 1'b0 : small_up);
  assign index_o = {up_bit, page_cache_disable_i, page_write_through_i};
endmodule

// ---- rtl/page_memory_type_select.sv ----
// page memory-type selection with its register file on apb
`timescale 1ns/100ps
module page_memory_type_select
  import mem_type_pkg::*;
(
  input  wire logic               clk_i,          // core clock
  input  wire logic               rst_n_i,        // async reset, active low
  input  wire logic               psel_i,         // apb select
  input  wire logic               penable_i,      // apb enable
  input  wire logic               pwrite_i,       // apb write
  input  wire logic [11:0]        paddr_i,        // apb byte address
  input  wire logic [31:0]        pwdata_i,       // apb write data
  output logic [31:0]             prdata_o,       // apb read data
  output logic                    pready_o,       // apb ready
  output logic                    pslverr_o,      // apb error
  input  wire logic               xlat_valid_i,   // translation request
  input  wire logic               large_page_i,   // large page translation
  input  wire logic [ENTRY_W-1:0] entry_i,        // final page entry
  input  wire logic               page_cache_disable_i, // entry bit
  input  wire logic               page_write_through_i, // entry bit
  output logic                    type_valid_o,   // memory type valid
  output logic [TYPE_W-1:0]       mem_type_o,     // selected memory type
  output logic                    order_hazard_o  // uncacheable may reorder
);
  logic [TYPE_W-1:0] memory_type_table [ENTRIES];
  logic [3:0]        ctrl;
  logic [IDX_W-1:0]  last_index;
  logic [IDX_W-1:0]  index;

  wire large_page_mode_enable       = ctrl[CTL_LPME];
  wire extended_address_mode_enable = ctrl[CTL_EAME];
  wire global_cache_disable         = ctrl[CTL_GCD];
  wire memory_range_type_regs       = ctrl[CTL_RANGE_EN];

  mem_type_index u_index (
    .large_page_i         (large_page_i),
    .entry_i              (entry_i),
    .page_cache_disable_i (page_cache_disable_i),
    .page_write_through_i (page_write_through_i),
    .lpme_i               (large_page_mode_enable),
    .eame_i               (extended_address_mode_enable),
    .index_o              (index)
  );

  function automatic logic [63:0] pack_table(
      input logic [TYPE_W-1:0] t [ENTRIES]);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < ENTRIES; i++) r[i*8 +: TYPE_W] = t[i];
    return r;
  endfunction

  wire [63:0] table_bits = pack_table(memory_type_table);
  // the leak needs the table exactly at reset contents; one edit ends it
  wire table_default = (table_bits == TABLE_RESET);
  wire [TYPE_W-1:0] raw_type = memory_type_table[index];
  // range regs off, caching on, default table: weak uc leaks as write back
  wire leak = !memory_range_type_regs && !global_cache_disable
              && table_default && raw_type == WEAK_UNCACHEABLE_TYPE;
  wire [TYPE_W-1:0] next_type =
      leak ? WRITE_BACK_TYPE
    : (global_cache_disable ? UNCACHEABLE_TYPE : raw_type);
  wire next_hazard = !memory_range_type_regs && global_cache_disable
                     && table_default;

  wire setup   = psel_i && !penable_i;
  wire access  = psel_i && penable_i;
  wire wr_en   = access && pwrite_i;
  wire hit_lo  = paddr_i == TABLE_LO_ADR;
  wire hit_hi  = paddr_i == TABLE_HI_ADR;
  wire hit_ctl = paddr_i == CTRL_ADR;
  wire hit_st  = paddr_i == STATUS_ADR;
  wire mapped  = hit_lo | hit_hi | hit_ctl | hit_st;
  // status: hazard at 8, valid at 7, type at 6:4, bit 3 zero, index at 2:0
  wire [31:0] rd_mux =
      hit_lo  ? table_bits[31:0]
    : hit_hi  ? table_bits[63:32]
    : hit_ctl ? {28'h0, ctrl}
    : hit_st  ? {23'h0, order_hazard_o, type_valid_o, mem_type_o,
                 1'b0, last_index}
    : 32'h0;

  // one process per entry keeps each write enable local to its byte lane
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_ent
      localparam int W = g / 4;
      localparam int B = (g % 4) * 8;
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          memory_type_table[g] <= TABLE_RESET[g*8 +: TYPE_W];
        end else if (wr_en && (W == 0 ? hit_lo : hit_hi)) begin
          memory_type_table[g] <= pwdata_i[B +: TYPE_W];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= CTRL_RESET;
    end else if (wr_en && hit_ctl) begin
      ctrl <= pwdata_i[3:0];
    end
  end

  // no wait state: ready in the first access cycle, read data taken at setup
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup && !mapped;
      prdata_o  <= (setup && !pwrite_i) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      type_valid_o   <= 1'b0;
      mem_type_o     <= UNCACHEABLE_TYPE;
      order_hazard_o <= 1'b0;
      last_index     <= '0;
    end else begin
      type_valid_o <= xlat_valid_i;
      // type and hazard hold between requests so the cache may sample late
      if (xlat_valid_i) begin
        mem_type_o     <= next_type;
        order_hazard_o <= next_hazard;
        last_index     <= index;
      end
    end
  end

  // outputs are registered, so each check but default_a looks one edge after the request
  // and takes request-side values through $past where it compares against them
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_apb_setup;
    psel_i && !penable_i;
  endsequence

  sequence s_apb_access;
    psel_i && penable_i;
  endsequence

  forced_zero_a: assert property (
    xlat_valid_i && !large_page_i
    && (large_page_mode_enable || extended_address_mode_enable)
    |=> last_index[IDX_W-1] == 1'b0)
    else $error("upper index bit not forced to zero");
  small_bit_a: assert property (
    xlat_valid_i && !large_page_i
    && !large_page_mode_enable && !extended_address_mode_enable
    |=> last_index[IDX_W-1] == $past(entry_i[SMALL_UP_BIT]))
    else $error("small page upper bit wrong");
  large_bit_a: assert property (
    xlat_valid_i && large_page_i
    |=> last_index[2] == $past(entry_i[LARGE_UP_BIT]))
    else $error("large page upper bit wrong");
  low_bits_a: assert property (
    xlat_valid_i |=> last_index[1:0] ==
      {$past(page_cache_disable_i), $past(page_write_through_i)})
    else $error("index low bits wrong");
  leak_wb_a: assert property (
    xlat_valid_i && leak |=> mem_type_o == WRITE_BACK_TYPE)
    else $error("weak uncacheable not shown as write back");
  hazard_a: assert property (
    xlat_valid_i |=> order_hazard_o == $past(next_hazard))
    else $error("ordering hazard flag wrong");
  apb_ready_a: assert property (
    s_apb_setup |=> pready_o ##1 !pready_o)
    else $error("apb ready timing wrong");
  table_write_a: assert property (
    wr_en && hit_lo |=> memory_type_table[0] == $past(pwdata_i[TYPE_W-1:0]))
    else $error("table entry not written");
  default_a: assert property (
    $rose(rst_n_i) |-> memory_type_table[2] == WEAK_UNCACHEABLE_TYPE)
    else $error("default weak uncacheable missing");

  apb_answer_a: assert property (
    s_apb_setup ##1 s_apb_access |-> pready_o)
    else $error("apb access not answered");
  apb_error_a: assert property (
    s_apb_setup |=> pslverr_o == !$past(mapped))
    else $error("apb error flag wrong");
  rd_idle_a: assert property (
    !(setup && !pwrite_i) |=> prdata_o == 32'h0)
    else $error("read data not idle");
  hi_write_a: assert property (
    wr_en && hit_hi
    |=> memory_type_table[ENTRIES-1] == $past(pwdata_i[24 +: TYPE_W]))
    else $error("upper table entry not written");
  ctrl_write_a: assert property (
    wr_en && hit_ctl |=> ctrl == $past(pwdata_i[3:0]))
    else $error("control word not written");
  valid_pulse_a: assert property (
    xlat_valid_i |=> type_valid_o)
    else $error("memory type valid missing");
  valid_drop_a: assert property (
    !xlat_valid_i |=> !type_valid_o)
    else $error("memory type valid without request");
  type_hold_a: assert property (
    !xlat_valid_i |=> $stable(mem_type_o) && $stable(order_hazard_o))
    else $error("memory type changed without request");
  other_type_a: assert property (
    xlat_valid_i && !global_cache_disable
    && raw_type != WEAK_UNCACHEABLE_TYPE
    |=> mem_type_o == $past(raw_type))
    else $error("table type not passed through");
  range_on_a: assert property (
    xlat_valid_i && memory_range_type_regs && !global_cache_disable
    |=> mem_type_o == $past(raw_type))
    else $error("type altered with ranges enabled");
  cache_off_a: assert property (
    xlat_valid_i && global_cache_disable
    |=> mem_type_o == UNCACHEABLE_TYPE)
    else $error("cache disable did not force uncacheable");
  no_hazard_a: assert property (
    xlat_valid_i && memory_range_type_regs |=> !order_hazard_o)
    else $error("ordering hazard with ranges enabled");
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the page memory-type selection block
`timescale 1ns/100ps
module tb;
  import mem_type_pkg::*;
  logic               clk_i = 1'b0;
  logic               rst_n_i = 1'b0;
  logic               psel_i = 1'b0;
  logic               penable_i = 1'b0;
  logic               pwrite_i = 1'b0;
  logic [11:0]        paddr_i = 12'h000;
  logic [31:0]        pwdata_i = 32'h0;
  logic [31:0]        prdata_o;
  logic               pready_o;
  logic               pslverr_o;
  logic               xlat_valid_i = 1'b0;
  logic               large_page_i = 1'b0;
  logic [ENTRY_W-1:0] entry_i = '0;
  logic               page_cache_disable_i = 1'b0;
  logic               page_write_through_i = 1'b0;
  logic               type_valid_o;
  logic [TYPE_W-1:0]  mem_type_o;
  logic               order_hazard_o;
  logic [31:0]        rd_data;
  logic               rd_err;
  int                 bad_count = 0;
  int                 cmp_count = 0;

  always #5 clk_i = ~clk_i;

  page_memory_type_select dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .xlat_valid_i(xlat_valid_i), .large_page_i(large_page_i),
    .entry_i(entry_i), .page_cache_disable_i(page_cache_disable_i),
    .page_write_through_i(page_write_through_i),
    .type_valid_o(type_valid_o), .mem_type_o(mem_type_o),
    .order_hazard_o(order_hazard_o));

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until the edge where pready is seen high
  task automatic apb(input logic wr, input logic [11:0] adr,
                     input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= adr;
    pwdata_i <= dat;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd_data = prdata_o;
    rd_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1) begin
      bad_count++;
      test_done();
    end
  endtask

  // upper index bit goes in the used position, its inverse in the other
  task automatic xlat(input logic lg, input logic [2:0] ix,
                      input logic [2:0] ty, input logic hz);
    @(posedge clk_i);
    xlat_valid_i <= 1'b1;
    large_page_i <= lg;
    entry_i <= lg ? {19'h0, ix[2], 4'h0, ~ix[2], 7'h0}
                  : {19'h0, ~ix[2], 4'h0, ix[2], 7'h0};
    page_cache_disable_i <= ix[1];
    page_write_through_i <= ix[0];
    @(posedge clk_i);
    xlat_valid_i <= 1'b0;
    #1;
    check({31'h0, type_valid_o}, 32'h1);
    check({29'h0, mem_type_o}, {29'h0, ty});
    check({31'h0, order_hazard_o}, {31'h0, hz});
    @(posedge clk_i);
    #1;
    check({31'h0, type_valid_o}, 32'h0);
    check({29'h0, mem_type_o}, {29'h0, ty});
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, TABLE_LO_ADR, 32'h0);
    check(rd_data, 32'h00070406);
    apb(1'b0, TABLE_HI_ADR, 32'h0);
    check(rd_data, 32'h00070406);
    apb(1'b0, 12'h010, 32'h0);
    check({31'h0, rd_err}, 32'h1);
    xlat(1'b0, 3'h2, 3'h7, 1'b0);
    apb(1'b1, CTRL_ADR, 32'h0);
    xlat(1'b0, 3'h2, 3'h6, 1'b0);
    apb(1'b0, STATUS_ADR, 32'h0);
    check(rd_data, 32'h00000062);
    check({31'h0, rd_err}, 32'h0);
    xlat(1'b0, 3'h1, 3'h4, 1'b0);
    apb(1'b1, CTRL_ADR, 32'h4);
    xlat(1'b0, 3'h2, 3'h0, 1'b1);
    apb(1'b0, STATUS_ADR, 32'h0);
    check(rd_data, 32'h00000102);
    apb(1'b1, CTRL_ADR, 32'h8);
    apb(1'b1, TABLE_LO_ADR, 32'h0);
    apb(1'b1, CTRL_ADR, 32'hC);
    apb(1'b1, CTRL_ADR, 32'h4);
    xlat(1'b0, 3'h2, 3'h0, 1'b0);
    apb(1'b1, TABLE_LO_ADR, 32'h03020100);
    apb(1'b1, TABLE_HI_ADR, 32'h07060504);
    for (int m = 8; m < 12; m++) begin
      apb(1'b1, CTRL_ADR, 32'(m));
      for (int i = 0; i < 8; i++) begin
        xlat(1'b0, 3'(i), (m[1:0] != 0) ? 3'(i & 3) : 3'(i), 1'b0);
        xlat(1'b1, 3'(i), 3'(i), 1'b0);
      end
    end
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, TABLE_HI_ADR, 32'h0);
    check(rd_data, 32'h00070406);
    apb(1'b0, TABLE_LO_ADR, 32'h0);
    check(rd_data, 32'h00070406);
    test_done();
  end
endmodule
